//--- logic/mal_alert_limit.sv
// Calibration, alarm enable/flag and threshold registers of the monitor,
// with the limit comparison and the open-drain alarm pin.
// Assumes a serial bus engine on the same clock hands over bytes and
// transaction starts, and the measurement path hands over results.
`timescale 1ns/10ps
`default_nettype none
`include "mal_defs.svh"

// Functional notes
// - Calibration register at 05h, bit 15 zero, bits 14..0 stored.
// - Several comparison enables set: only the highest one is used.
// - Shunt-over enabled: alarm when shunt result exceeds threshold.
// - Shunt-under enabled: alarm when shunt result is below threshold.
// - Bus-over enabled: alarm when bus result exceeds threshold.
// - Bus-under enabled: alarm when bus result is below threshold.
// - Power-over enabled: alarm when power result exceeds threshold.
// - Ready alarm enable also raises alarm while conversion done is set.
// - Source flag marks alarms caused by the comparison function.
// - Latched: source flag clears on enable read; else next clean result.
// - Conversion done sets once a full measurement cycle finished.
// - Conversion done clears on active-mode config write or enable read.
// - Overflow flag follows whether the latest math operation overflowed.
// - Invert bit 0 gives active-low alarm pin, 1 gives active-high.
// - Transparent mode: pin and source flag idle once fault is gone.
// - Latched mode: pin and source flag hold until enable register read.
// - Threshold register at 07h, reset zero, compared with chosen result.
// - Enable and flag register at 06h, resets zero, bits 9..5 unused.
// - Shunt comparisons are signed twos complement.
// - Write is pointer byte then high and low data bytes.
// - Read returns pointer-selected register, high byte first.
module mal_alert_limit (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_wr_start,
  input wire logic i_wr_byte_valid,
  input wire mal_pkg::mal_byte_t i_wr_byte,
  input wire logic i_rd_start,
  input wire logic i_rd_byte_ack,
  input wire logic i_result_valid,
  input wire mal_pkg::mal_word_t i_shunt,
  input wire mal_pkg::mal_word_t i_bus,
  input wire mal_pkg::mal_word_t i_power,
  input wire logic i_overflow,
  input wire logic i_cfg_active_write,
  input wire logic i_alert_in,
  output logic o_alert_out,
  output logic o_alert_oe_n,
  output mal_pkg::mal_byte_t o_rd_byte,
  output logic [`MAL_CAL_MSB:0] o_cal_value
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  mal_pkg::mal_wb_e wb_state_reg;
  mal_pkg::mal_byte_t ptr_reg;
  mal_pkg::mal_byte_t wr_high_reg;
  mal_pkg::mal_word_t rd_word_reg;
  mal_pkg::mal_word_t thresh_reg;
  logic [`MAL_EN_W-1:0] en_reg;
  logic inv_reg;
  logic latch_reg;
  logic src_reg;
  logic done_reg;
  logic ovf_reg;
  logic fn_fault;
  logic commit;
  logic rd_alarm;
  logic src_next;
  logic done_next;
  logic inv_next;
  logic rdy_en_next;

  function automatic logic is_ptr(input mal_pkg::mal_byte_t p,
                                  input mal_pkg::mal_byte_t v);
    is_ptr = (p == v);
  endfunction

  // ----------------------------------------
  // Limit comparison
  // ----------------------------------------
  mal_limit_compare u_cmp (
    .i_fn_enable(en_reg[`MAL_EN_W-1:1]),
    .i_shunt(i_shunt),
    .i_bus(i_bus),
    .i_power(i_power),
    .i_limit(thresh_reg),
    .o_fault(fn_fault)
  );

  // ----------------------------------------
  // Byte sequencing of writes
  // ----------------------------------------
  // A new start always expects a pointer byte; bytes after the low data
  // byte are acknowledged by the engine but ignored here.
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wb_state_reg <= mal_pkg::MAL_WB_POINTER;
    end else if (i_wr_start) begin
      wb_state_reg <= mal_pkg::MAL_WB_POINTER;
    end else if (i_wr_byte_valid) begin
      case (wb_state_reg)
        mal_pkg::MAL_WB_POINTER: wb_state_reg <= mal_pkg::MAL_WB_HIGH;
        mal_pkg::MAL_WB_HIGH: wb_state_reg <= mal_pkg::MAL_WB_LOW;
        mal_pkg::MAL_WB_LOW: wb_state_reg <= mal_pkg::MAL_WB_SPENT;
        default: wb_state_reg <= mal_pkg::MAL_WB_SPENT;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ptr_reg <= `MAL_PTR_RST;
    end else if (i_wr_byte_valid && !i_wr_start &&
                 wb_state_reg == mal_pkg::MAL_WB_POINTER) begin
      ptr_reg <= i_wr_byte;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_high_reg <= `MAL_BYTE_RST;
    end else if (i_wr_byte_valid && !i_wr_start &&
                 wb_state_reg == mal_pkg::MAL_WB_HIGH) begin
      wr_high_reg <= i_wr_byte;
    end
  end

  // The word is stored only when its low byte arrives, so a transfer cut
  // short after the high byte leaves the register untouched.
  assign commit = i_wr_byte_valid && !i_wr_start &&
                  wb_state_reg == mal_pkg::MAL_WB_LOW;

  // ----------------------------------------
  // Writable registers
  // ----------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_cal_value <= (`MAL_CAL_MSB+1)'(`MAL_WORD_RST);
    end else if (commit && is_ptr(ptr_reg, `MAL_PTR_CAL)) begin
      o_cal_value <= {wr_high_reg[`MAL_CAL_MSB-8:0], i_wr_byte};
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      thresh_reg <= `MAL_WORD_RST;
    end else if (commit && is_ptr(ptr_reg, `MAL_PTR_THRESH)) begin
      thresh_reg <= {wr_high_reg, i_wr_byte};
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      en_reg <= `MAL_EN_W'(`MAL_WORD_RST);
      inv_reg <= 1'b0;
      latch_reg <= 1'b0;
    end else if (commit && is_ptr(ptr_reg, `MAL_PTR_ALARM)) begin
      en_reg <= wr_high_reg[`MAL_EN_MSB-8:`MAL_EN_LSB-8];
      inv_reg <= i_wr_byte[`MAL_BIT_INV];
      latch_reg <= i_wr_byte[`MAL_BIT_LATCH];
    end
  end

  // ----------------------------------------
  // Flags
  // ----------------------------------------
  // The enable register is read when a read transfer starts on it; the
  // word is captured in that same cycle, so the host sees the flags as
  // they were before the clear.
  assign rd_alarm = i_rd_start && is_ptr(ptr_reg, `MAL_PTR_ALARM);

  // A new result with a fault wins over a clearing read in the same cycle.
  always_comb begin
    src_next = src_reg;
    if (rd_alarm && latch_reg) begin
      src_next = 1'b0;
    end
    if (i_result_valid) begin
      if (fn_fault) begin
        src_next = 1'b1;
      end else if (!latch_reg) begin
        src_next = 1'b0;
      end
    end
  end

  always_comb begin
    done_next = done_reg;
    if (rd_alarm || i_cfg_active_write) begin
      done_next = 1'b0;
    end
    if (i_result_valid) begin
      done_next = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      src_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      src_reg <= src_next;
      done_reg <= done_next;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ovf_reg <= 1'b0;
    end else if (i_result_valid) begin
      ovf_reg <= i_overflow;
    end
  end

  // ----------------------------------------
  // Alarm pin
  // ----------------------------------------
  // The pin is computed from the next flag values so that it moves on the
  // same edge as the flags. The pin level is an open-drain pull-down only;
  // the sensed level is not used by this block.
  assign inv_next = (commit && is_ptr(ptr_reg, `MAL_PTR_ALARM)) ?
                    i_wr_byte[`MAL_BIT_INV] : inv_reg;
  assign rdy_en_next = (commit && is_ptr(ptr_reg, `MAL_PTR_ALARM)) ?
                       wr_high_reg[`MAL_EN_LSB-8] : en_reg[0];

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_alert_out <= 1'b0;
      o_alert_oe_n <= 1'b1;
    end else begin
      o_alert_out <= 1'b0;
      o_alert_oe_n <= !((src_next || (rdy_en_next && done_next)) ^
                        inv_next);
    end
  end

  // ----------------------------------------
  // Reads
  // ----------------------------------------
  // Pointers outside this block read as zero here; the serial engine
  // chooses between this byte and those of the other register banks.
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rd_word_reg <= `MAL_WORD_RST;
    end else if (i_rd_start) begin
      if (is_ptr(ptr_reg, `MAL_PTR_CAL)) begin
        rd_word_reg <= {1'b0, o_cal_value};
      end else if (is_ptr(ptr_reg, `MAL_PTR_ALARM)) begin
        rd_word_reg <= {en_reg, `MAL_UNUSED_W'(`MAL_WORD_RST), src_reg,
                        done_reg, ovf_reg, inv_reg, latch_reg};
      end else if (is_ptr(ptr_reg, `MAL_PTR_THRESH)) begin
        rd_word_reg <= thresh_reg;
      end else begin
        rd_word_reg <= `MAL_WORD_RST;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rd_byte <= `MAL_BYTE_RST;
    end else if (i_rd_start) begin
      if (is_ptr(ptr_reg, `MAL_PTR_CAL)) begin
        o_rd_byte <= {1'b0, o_cal_value[`MAL_CAL_MSB:8]};
      end else if (is_ptr(ptr_reg, `MAL_PTR_ALARM)) begin
        o_rd_byte <= {en_reg, 2'h0};
      end else if (is_ptr(ptr_reg, `MAL_PTR_THRESH)) begin
        o_rd_byte <= thresh_reg[15:8];
      end else begin
        o_rd_byte <= `MAL_BYTE_RST;
      end
    end else if (i_rd_byte_ack) begin
      o_rd_byte <= rd_word_reg[7:0];
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_cal_write;
    commit && is_ptr(ptr_reg, `MAL_PTR_CAL);
  endsequence

  property p_cal_write;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    s_cal_write |=> o_cal_value ==
      {$past(wr_high_reg[`MAL_CAL_MSB-8:0]), $past(i_wr_byte)};
  endproperty
  a_cal_write: assert property (p_cal_write)
    else $error("Calibration word not stored after low byte.");

  property p_thresh_write;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    commit && is_ptr(ptr_reg, `MAL_PTR_THRESH) |=>
      thresh_reg == {$past(wr_high_reg), $past(i_wr_byte)};
  endproperty
  a_thresh_write: assert property (p_thresh_write)
    else $error("Threshold word not stored after low byte.");

  property p_done_set;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    i_result_valid |=> done_reg;
  endproperty
  a_done_set: assert property (p_done_set)
    else $error("Conversion done flag not set after result.");

  property p_done_clear;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    (rd_alarm || i_cfg_active_write) && !i_result_valid |=> !done_reg;
  endproperty
  a_done_clear: assert property (p_done_clear)
    else $error("Conversion done flag not cleared.");

  property p_ovf_follow;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    i_result_valid |=> ovf_reg == $past(i_overflow);
  endproperty
  a_ovf_follow: assert property (p_ovf_follow)
    else $error("Overflow flag does not follow the latest result.");

  property p_src_set;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    i_result_valid && fn_fault |=> src_reg;
  endproperty
  a_src_set: assert property (p_src_set)
    else $error("Source flag not set on a comparison fault.");

  property p_src_transparent;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    i_result_valid && !fn_fault && !latch_reg |=> !src_reg;
  endproperty
  a_src_transparent: assert property (p_src_transparent)
    else $error("Transparent source flag not released.");

  property p_src_latched;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    src_reg && latch_reg && !rd_alarm |=> src_reg;
  endproperty
  a_src_latched: assert property (p_src_latched)
    else $error("Latched source flag dropped without a read.");

  property p_pin_level;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    ##1 o_alert_oe_n == !((src_reg || (en_reg[0] && done_reg)) ^ inv_reg);
  endproperty
  a_pin_level: assert property (p_pin_level)
    else $error("Alarm pin disagrees with flags and polarity.");

  sequence s_read_word;
    i_rd_start && !i_wr_byte_valid ##1 i_rd_byte_ack && !i_rd_start;
  endsequence

  property p_read_order;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    s_read_word |=> o_rd_byte == $past(rd_word_reg[7:0]) &&
      $past(o_rd_byte) == $past(rd_word_reg[15:8]);
  endproperty
  a_read_order: assert property (p_read_order)
    else $error("Read bytes not returned high byte first.");

endmodule
`default_nettype wire

//--- logic/mal_defs.svh
// Offsets, field positions, reset values and widths of the alarm logic.
// Assumes it is included by bare name from files under logic/.
`ifndef MAL_DEFS_SVH
`define MAL_DEFS_SVH

// ----------------------------------------
// Register pointer values
// ----------------------------------------
`define MAL_PTR_CAL 8'h05
`define MAL_PTR_ALARM 8'h06
`define MAL_PTR_THRESH 8'h07

// ----------------------------------------
// Field layout
// ----------------------------------------
`define MAL_CAL_MSB 14
`define MAL_EN_MSB 15
`define MAL_EN_LSB 10
`define MAL_EN_W 6
`define MAL_UNUSED_W 5
`define MAL_BIT_SRC 4
`define MAL_BIT_DONE 3
`define MAL_BIT_OVF 2
`define MAL_BIT_INV 1
`define MAL_BIT_LATCH 0
`define MAL_FN_W 5

// ----------------------------------------
// Reset values
// ----------------------------------------
`define MAL_WORD_RST 16'h0000
`define MAL_BYTE_RST 8'h00
`define MAL_PTR_RST 8'h00

`endif

//--- logic/mal_limit_compare.sv
// Selects one comparison function and compares a result with the limit.
// Assumes all inputs are stable results on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "mal_defs.svh"
module mal_limit_compare (
  input wire logic [`MAL_FN_W-1:0] i_fn_enable,
  input wire mal_pkg::mal_word_t i_shunt,
  input wire mal_pkg::mal_word_t i_bus,
  input wire mal_pkg::mal_word_t i_power,
  input wire mal_pkg::mal_word_t i_limit,
  output logic o_fault
);
  // Enable bits, highest first: shunt over, shunt under, bus over,
  // bus under, power over. Only the highest set one is looked at.
  always_comb begin
    o_fault = 1'b0;
    if (i_fn_enable[4]) begin
      o_fault = $signed(i_shunt) > $signed(i_limit);
    end else if (i_fn_enable[3]) begin
      o_fault = $signed(i_shunt) < $signed(i_limit);
    end else if (i_fn_enable[2]) begin
      o_fault = i_bus > i_limit;
    end else if (i_fn_enable[1]) begin
      o_fault = i_bus < i_limit;
    end else if (i_fn_enable[0]) begin
      o_fault = i_power > i_limit;
    end
  end
endmodule
`default_nettype wire

//--- logic/mal_pkg.sv
// Types shared by the alarm logic of the monitor.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package mal_pkg;
  typedef logic [15:0] mal_word_t;
  typedef logic [7:0] mal_byte_t;
  // Position within a write transaction, Gray coded along its path.
  typedef enum logic [1:0] {
    MAL_WB_POINTER = 2'h0,
    MAL_WB_HIGH = 2'h1,
    MAL_WB_LOW = 2'h3,
    MAL_WB_SPENT = 2'h2
  } mal_wb_e;
endpackage
`default_nettype wire

//--- verification/mal_host_model.sv
// Byte-level model of the serial bus host seen by the alarm registers.
// Assumes the block samples its request strobes on the rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module mal_host_model (
  input wire logic i_clk_sys,
  input wire mal_pkg::mal_byte_t i_rd_byte,
  output logic o_wr_start,
  output logic o_wr_byte_valid,
  output mal_pkg::mal_byte_t o_wr_byte,
  output logic o_rd_start,
  output logic o_rd_byte_ack
);
  initial begin
    o_wr_start = 1'b0;
    o_wr_byte_valid = 1'b0;
    o_wr_byte = 8'hA5;
    o_rd_start = 1'b0;
    o_rd_byte_ack = 1'b0;
  end

  task automatic tick;
    @(posedge i_clk_sys);
    #1;
  endtask

  // A non-zero gap idles between bytes, as a slow host would. Released
  // data is inverted so a stale byte is never mistaken for a fresh one.
  task automatic send(input mal_pkg::mal_byte_t b, input int gap);
    o_wr_byte_valid = 1'b1;
    o_wr_byte = b;
    tick();
    repeat (gap) begin
      o_wr_byte_valid = 1'b0;
      o_wr_byte = ~b;
      tick();
    end
  endtask

  task automatic write(input mal_pkg::mal_byte_t ptr,
                       input mal_pkg::mal_word_t d, input logic data_too,
                       input int gap);
    tick();
    o_wr_start = 1'b1;
    tick();
    o_wr_start = 1'b0;
    send(ptr, gap);
    if (data_too) begin
      send(d[15:8], gap);
      send(d[7:0], gap);
    end
    o_wr_byte_valid = 1'b0;
    o_wr_byte = ~o_wr_byte;
    repeat (2) tick();
  endtask

  task automatic read(output mal_pkg::mal_word_t w);
    tick();
    o_rd_start = 1'b1;
    tick();
    o_rd_start = 1'b0;
    o_rd_byte_ack = 1'b1;
    w[15:8] = i_rd_byte;
    tick();
    o_rd_byte_ack = 1'b0;
    w[7:0] = i_rd_byte;
  endtask
endmodule
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench for the alarm register block.
// Assumes the host model drives the serial side and the bench the results.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk, rst_n, rv, ovf, cfgw, wst, wbv, rds, ack, aout, oe_n, pin;
  mal_pkg::mal_byte_t wb, rb;
  mal_pkg::mal_word_t sh, bu, pw, w;
  logic [14:0] cal;
  int n_mismatch = 0;
  int total_checks = 0;
  mal_pkg::mal_word_t en_t[5] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000,
                                  16'h0800};
  mal_pkg::mal_word_t th_t[5] = '{16'hFFF0, 16'hFFF0, 16'h1000, 16'h1000,
                                  16'h8000};
  mal_pkg::mal_word_t tr_t[5] = '{16'h0005, 16'hFF00, 16'h1001, 16'h0FFF,
                                  16'h8001};
  mal_pkg::mal_word_t cl_t[5] = '{16'h8000, 16'h0001, 16'h1000, 16'h1000,
                                  16'h8000};

  // Open-drain pin with a pull-up.
  assign pin = oe_n ? 1'b1 : aout;

  mal_alert_limit mal_alert_limit_i (.i_clk_sys(clk), .i_reset_n(rst_n),
    .i_wr_start(wst), .i_wr_byte_valid(wbv), .i_wr_byte(wb),
    .i_rd_start(rds), .i_rd_byte_ack(ack), .i_result_valid(rv),
    .i_shunt(sh), .i_bus(bu), .i_power(pw), .i_overflow(ovf),
    .i_cfg_active_write(cfgw), .i_alert_in(pin), .o_alert_out(aout),
    .o_alert_oe_n(oe_n), .o_rd_byte(rb), .o_cal_value(cal));

  mal_host_model mal_host_model_i (.i_clk_sys(clk), .i_rd_byte(rb),
    .o_wr_start(wst), .o_wr_byte_valid(wbv), .o_wr_byte(wb),
    .o_rd_start(rds), .o_rd_byte_ack(ack));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk_word(input mal_pkg::mal_word_t got,
                          input mal_pkg::mal_word_t exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t pin %b expected %b", $time, got, exp);
    end
  endtask

  task automatic wr(input mal_pkg::mal_byte_t p, input mal_pkg::mal_word_t d);
    mal_host_model_i.write(p, d, 1'b1, 0);
  endtask

  task automatic rd_chk(input mal_pkg::mal_byte_t p,
                        input mal_pkg::mal_word_t exp);
    mal_host_model_i.write(p, 16'h0000, 1'b0, 0);
    mal_host_model_i.read(w);
    chk_word(w, exp);
  endtask

  task automatic meas(input mal_pkg::mal_word_t v, input logic o);
    @(posedge clk);
    #1;
    rv = 1'b1;
    {sh, bu, pw, ovf} = {v, v, v, o};
    @(posedge clk);
    #1;
    rv = 1'b0;
    {sh, bu, pw, ovf} = {~v, ~v, ~v, ~o};
    @(posedge clk);
    #1;
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk_bit(oe_n, 1'b1);
    rd_chk(8'h05, 16'h0000);
    rd_chk(8'h06, 16'h0000);
    rd_chk(8'h07, 16'h0000);
    rd_chk(8'h08, 16'h0000);
  endtask

  task automatic t_regs;
    wr(8'h05, 16'hFFFF);
    rd_chk(8'h05, 16'h7FFF);
    chk_word({1'b0, cal}, 16'h7FFF);
    mal_host_model_i.write(8'h07, 16'hA55A, 1'b1, 3);
    rd_chk(8'h07, 16'hA55A);
    mal_host_model_i.read(w);
    chk_word(w, 16'hA55A);
    wr(8'h06, 16'hFFFF);
    rd_chk(8'h06, 16'hFC03);
    wr(8'h06, 16'h0000);
  endtask

  task automatic t_funcs;
    for (int i = 0; i < 5; i++) begin
      wr(8'h06, en_t[i]);
      wr(8'h07, th_t[i]);
      meas(tr_t[i], 1'b0);
      chk_bit(oe_n, 1'b0);
      chk_bit(pin, 1'b0);
      rd_chk(8'h06, en_t[i] | 16'h0018);
      meas(cl_t[i], 1'b0);
      chk_bit(oe_n, 1'b1);
      rd_chk(8'h06, en_t[i] | 16'h0008);
    end
  endtask

  task automatic t_prio;
    wr(8'h06, 16'h9000);
    wr(8'h07, 16'h1000);
    meas(16'h0FFF, 1'b0);
    chk_bit(oe_n, 1'b1);
    meas(16'h1001, 1'b0);
    chk_bit(oe_n, 1'b0);
    meas(16'h0FFF, 1'b0);
  endtask

  task automatic t_latch;
    wr(8'h06, 16'h2001);
    wr(8'h07, 16'h1000);
    meas(16'h1001, 1'b0);
    meas(16'h1000, 1'b0);
    chk_bit(oe_n, 1'b0);
    rd_chk(8'h06, 16'h2019);
    chk_bit(oe_n, 1'b1);
    rd_chk(8'h06, 16'h2001);
  endtask

  task automatic t_pol;
    wr(8'h06, 16'h2002);
    chk_bit(oe_n, 1'b0);
    meas(16'h1001, 1'b0);
    chk_bit(oe_n, 1'b1);
    chk_bit(pin, 1'b1);
    meas(16'h1000, 1'b0);
    chk_bit(oe_n, 1'b0);
  endtask

  task automatic t_ready;
    wr(8'h06, 16'h0400);
    chk_bit(oe_n, 1'b0);
    rd_chk(8'h06, 16'h0408);
    chk_bit(oe_n, 1'b1);
    meas(16'h0000, 1'b0);
    chk_bit(oe_n, 1'b0);
    cfgw = 1'b1;
    @(posedge clk);
    #1;
    cfgw = 1'b0;
    @(posedge clk);
    #1;
    chk_bit(oe_n, 1'b1);
    meas(16'h0000, 1'b1);
    rd_chk(8'h06, 16'h040C);
    chk_bit(oe_n, 1'b1);
    meas(16'h0000, 1'b0);
    rd_chk(8'h06, 16'h0408);
  endtask

  // A reset in mid-run must bring back every register and a released pin.
  task automatic t_rerun;
    wr(8'h06, 16'h0002);
    chk_bit(oe_n, 1'b0);
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_reset();
  endtask

  // ----------------------------------------
  // Clock, reset, sequence and watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    {rst_n, rv, ovf, cfgw} = 4'h0;
    {sh, bu, pw} = {16'h0000, 16'h0000, 16'h0000};
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_regs();
    t_funcs();
    t_prio();
    t_latch();
    t_pol();
    t_ready();
    t_rerun();
    print_verdict();
  end

  // The whole sequence needs well under 2000 cycles.
  initial begin
    #200000;
    n_mismatch++;
    print_verdict();
  end
endmodule
`default_nettype wire
